// ===== hw/swp_pkg.sv
// Purpose: shared constants and types for the sleep/wake power control link
// Assumes: one clock, the low power oscillator clock, on both ends
// Notes:   timing counts are in low power oscillator cycles
package swp_pkg;

  // transport selection for wake signalling
  typedef enum logic [1:0] {
    SWP_XPORT_PINS,
    SWP_XPORT_UART,
    SWP_XPORT_SPI
  } swp_xport_t;

  // sleep controller states
  typedef enum logic [2:0] {
    SWP_ST_OFF,
    SWP_ST_AWAKE,
    SWP_ST_SLEEP,
    SWP_ST_EVENT
  } swp_state_t;

  localparam int          SWP_TIMER_W        = 16;
  localparam int          SWP_IDLE_W         = 16;
  localparam logic [15:0] SWP_EVENT_LEN_RST  = 16'h0010;
  localparam logic [15:0] SWP_PERIOD_RST     = 16'h0100;
  localparam logic [15:0] SWP_IDLE_RST       = 16'h0040;
  // reset polarity of the device wake request: active low
  localparam logic        SWP_DEV_WAKE_POL_RST  = 1'b0;
  localparam logic        SWP_HOST_WAKE_POL_RST = 1'b1;
  // rf power-down bit positions
  localparam int          SWP_PD_TX   = 0;
  localparam int          SWP_PD_RX   = 1;
  localparam int          SWP_PD_PLL  = 2;
  localparam int          SWP_PD_PA   = 3;
  localparam int          SWP_PD_W    = 4;

endpackage

// ===== hw/swp_if.sv
// Purpose: wire bundle between the host and the device wake/power pins
// Assumes: both ends run on the same low power oscillator clock
// Notes:   the testbench joins each end's pins through this bundle
`timescale 1ns/100ps
interface swp_if;
  logic dev_wake_req;       // dedicated wake pin, host to device
  logic host_wake_req;      // dedicated wake pin, device to host
  logic uart_cts;           // in-band host to device wake
  logic uart_rts;           // in-band device to host wake
  logic host_port_select_n; // spi chip select
  logic host_irq;           // spi interrupt, device to host
  logic regulator_enable;   // power reset from host

  modport device (
    input  dev_wake_req, uart_cts, host_port_select_n, regulator_enable,
    output host_wake_req, uart_rts, host_irq
  );
  modport host (
    output dev_wake_req, uart_cts, host_port_select_n, regulator_enable,
    input  host_wake_req, uart_rts, host_irq
  );
endinterface

// ===== hw/swp_device.sv
// Purpose: device end sleep controller, wake pins, clock request, rf power-down
// Assumes: clk is the low power oscillator, always running while powered
// Notes:   configuration arrives as plain ports from firmware-owned registers
//
// How it works
// - sleep gates nonessential power, core stays retained
// - sleep timer on oscillator, wakes on time/host
// - scan/sniff event wakes then resleeps
// - event period timer runs on oscillator
// - host may wake device anytime while idle
// - host wake keeps device awake between events
// - dropping wake status allows sleep
// - host wake output, device wake input
// - uart cts/rts double as wake lines
// - spi idle for programmed time allows sleep
// - host programs spi idle sleep and time
// - asserting chip select wakes device
// - pending data raises host interrupt while host asleep
// - device wake request holds device awake
// - device wake polarity configurable, default low
// - host wake polarity configurable
// - refclk request while reference needed
// - strap sets refclk request polarity
// - regulator enable turns regulators on
// - separate tx, rx, pll, pa power-downs
// - host reinitialises after regulator power-up
`timescale 1ns/100ps
module swp_device #(
  parameter int TIMER_W = swp_pkg::SWP_TIMER_W,
  parameter int IDLE_W  = swp_pkg::SWP_IDLE_W
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // pins toward the host
  swp_if.device                              pins,
  // strap
  input  wire logic                          refclk_polarity_strap,
  // firmware configuration
  input  wire swp_pkg::swp_xport_t           xport_mode,
  input  wire logic                          sleep_enable,
  input  wire logic                          dev_wake_pol,
  input  wire logic                          host_wake_pol,
  input  wire logic                          spi_idle_sleep_en,
  input  wire logic [IDLE_W-1:0]             spi_idle_time,
  input  wire logic                          session_enable,
  input  wire logic [TIMER_W-1:0]            event_period,
  input  wire logic [TIMER_W-1:0]            timed_wake,
  input  wire logic                          timed_wake_en,
  // core activity
  input  wire logic                          event_done,
  input  wire logic                          data_pending,
  input  wire logic                          host_asleep,
  input  wire logic                          rf_tx_active,
  input  wire logic                          rf_rx_active,
  // power and clock outputs
  output logic                               regulators_on,
  output logic                               core_retain,
  output logic                               nonessential_pwr_on,
  output logic                               nonessential_clk_en,
  output logic                               refclk_request,
  output logic                               event_active,
  output logic                               fresh_power,
  output logic [swp_pkg::SWP_PD_W-1:0]       rf_power_down,
  output logic                               awake
);

  typedef struct packed {
    logic [2:0]                     wake_sy;
    logic [2:0]                     cts_sy;
    logic [2:0]                     cs_sy;
    logic [2:0]                     reg_sy;
    logic                           wake_lvl;
    logic                           cts_lvl;
    logic                           cs_lvl;
    logic                           reg_lvl;
    logic                           strap_cap;
    logic                           strap_done;
    swp_pkg::swp_state_t            st;
    logic [TIMER_W-1:0]             period_cnt;
    logic [TIMER_W-1:0]             timer_cnt;
    logic [IDLE_W-1:0]              idle_cnt;
    logic                           timed_fired;
    logic                           host_wake;
    logic                           irq;
    logic                           fresh;
    logic [swp_pkg::SWP_PD_W-1:0]   pd;
  } swp_dev_state_t;

  swp_dev_state_t cur_ff;
  swp_dev_state_t nxt_cur;

  logic host_req;
  logic spi_idle;
  logic may_sleep;
  logic need_ref;

  always_comb begin
    nxt_cur = cur_ff;
    // pin inputs: three flops, a change counts once stages two and three agree
    nxt_cur.wake_sy = {cur_ff.wake_sy[1:0], pins.dev_wake_req};
    nxt_cur.cts_sy  = {cur_ff.cts_sy[1:0], pins.uart_cts};
    nxt_cur.cs_sy   = {cur_ff.cs_sy[1:0], pins.host_port_select_n};
    nxt_cur.reg_sy  = {cur_ff.reg_sy[1:0], pins.regulator_enable};
    if (cur_ff.wake_sy[1] == cur_ff.wake_sy[2]) nxt_cur.wake_lvl = cur_ff.wake_sy[2];
    if (cur_ff.cts_sy[1] == cur_ff.cts_sy[2])   nxt_cur.cts_lvl  = cur_ff.cts_sy[2];
    if (cur_ff.cs_sy[1] == cur_ff.cs_sy[2])     nxt_cur.cs_lvl   = cur_ff.cs_sy[2];
    if (cur_ff.reg_sy[1] == cur_ff.reg_sy[2])   nxt_cur.reg_lvl  = cur_ff.reg_sy[2];

    // strap caught once after reset release
    if (!cur_ff.strap_done) begin
      nxt_cur.strap_cap  = refclk_polarity_strap;
      nxt_cur.strap_done = 1'b1;
    end

    // host wake request: pin or uart cts, polarity applied; spi select is low-active
    unique case (xport_mode)
      swp_pkg::SWP_XPORT_UART: host_req = (cur_ff.cts_lvl == dev_wake_pol);
      swp_pkg::SWP_XPORT_SPI:  host_req = !cur_ff.cs_lvl;
      default:                 host_req = (cur_ff.wake_lvl == dev_wake_pol);
    endcase

    // spi idle counter, restarts on any chip select activity
    spi_idle = 1'b1;
    if (xport_mode == swp_pkg::SWP_XPORT_SPI) begin
      if (!cur_ff.cs_lvl) begin
        nxt_cur.idle_cnt = '0;
      end else if (cur_ff.idle_cnt != spi_idle_time) begin
        nxt_cur.idle_cnt = cur_ff.idle_cnt + 1'b1;
      end
      spi_idle = spi_idle_sleep_en && (cur_ff.idle_cnt == spi_idle_time);
    end

    // removing wake status lets the device sleep when criteria hold
    may_sleep = sleep_enable && !host_req && spi_idle && !data_pending;

    // period timer free-runs on the oscillator while a session is enabled
    if (session_enable) begin
      if (cur_ff.period_cnt >= event_period) nxt_cur.period_cnt = '0;
      else nxt_cur.period_cnt = cur_ff.period_cnt + 1'b1;
    end else begin
      nxt_cur.period_cnt = '0;
    end

    // programmed timed wake, counted only during sleep
    if (cur_ff.st == swp_pkg::SWP_ST_SLEEP && timed_wake_en) begin
      nxt_cur.timer_cnt = cur_ff.timer_cnt + 1'b1;
      if (cur_ff.timer_cnt == timed_wake) nxt_cur.timed_fired = 1'b1;
    end else begin
      nxt_cur.timer_cnt   = '0;
      nxt_cur.timed_fired = 1'b0;
    end

    unique case (cur_ff.st)
      swp_pkg::SWP_ST_OFF: begin
        if (cur_ff.reg_lvl) nxt_cur.st = swp_pkg::SWP_ST_AWAKE;
      end
      swp_pkg::SWP_ST_AWAKE: begin
        if (may_sleep && !event_active) nxt_cur.st = swp_pkg::SWP_ST_SLEEP;
      end
      swp_pkg::SWP_ST_SLEEP: begin
        // host request wins at any moment
        if (host_req || cur_ff.timed_fired || data_pending) begin
          nxt_cur.st = swp_pkg::SWP_ST_AWAKE;
        end else if (session_enable && cur_ff.period_cnt >= event_period) begin
          nxt_cur.st = swp_pkg::SWP_ST_EVENT;
        end
      end
      swp_pkg::SWP_ST_EVENT: begin
        // session continues; host request keeps the device up afterwards
        if (event_done) begin
          nxt_cur.st = host_req ? swp_pkg::SWP_ST_AWAKE
                                : swp_pkg::SWP_ST_SLEEP;
        end
      end
      default: nxt_cur.st = swp_pkg::SWP_ST_OFF;
    endcase
    // regulator disable is a power reset from any state
    if (!cur_ff.reg_lvl) nxt_cur.st = swp_pkg::SWP_ST_OFF;

    // fresh power flag until host activity after power-up
    if (cur_ff.st == swp_pkg::SWP_ST_OFF) nxt_cur.fresh = 1'b1;
    else if (host_req) nxt_cur.fresh = 1'b0;

    // host wake and interrupt on pending data
    nxt_cur.host_wake = data_pending && cur_ff.st != swp_pkg::SWP_ST_OFF;
    nxt_cur.irq       = data_pending && host_asleep
                        && cur_ff.st != swp_pkg::SWP_ST_OFF;

    // per-path rf power-downs: everything down unless awake or in an event
    nxt_cur.pd = '1;
    if (cur_ff.st == swp_pkg::SWP_ST_AWAKE || cur_ff.st == swp_pkg::SWP_ST_EVENT) begin
      nxt_cur.pd[swp_pkg::SWP_PD_TX]  = !rf_tx_active;
      nxt_cur.pd[swp_pkg::SWP_PD_PA]  = !rf_tx_active;
      nxt_cur.pd[swp_pkg::SWP_PD_RX]  = !rf_rx_active;
      nxt_cur.pd[swp_pkg::SWP_PD_PLL] = !(rf_tx_active || rf_rx_active);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '{wake_sy: 3'h7, cts_sy: 3'h7, cs_sy: 3'h7, reg_sy: 3'h0,
                 wake_lvl: 1'b1, cts_lvl: 1'b1, cs_lvl: 1'b1, reg_lvl: 1'b0,
                 strap_cap: 1'b0, strap_done: 1'b0, st: swp_pkg::SWP_ST_OFF,
                 period_cnt: '0, timer_cnt: '0, idle_cnt: '0, timed_fired: 1'b0,
                 host_wake: 1'b0, irq: 1'b0, fresh: 1'b1, pd: '1};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign awake               = cur_ff.st == swp_pkg::SWP_ST_AWAKE;
  assign event_active        = cur_ff.st == swp_pkg::SWP_ST_EVENT;
  assign regulators_on       = cur_ff.reg_lvl;
  // retention only needs power, not the sleep state
  assign core_retain         = cur_ff.st != swp_pkg::SWP_ST_OFF;
  assign nonessential_pwr_on = awake || event_active;
  assign nonessential_clk_en = awake || event_active;
  assign need_ref            = awake || event_active;
  assign refclk_request      = (need_ref == cur_ff.strap_cap)
                               && cur_ff.strap_done;
  assign fresh_power         = cur_ff.fresh;
  assign rf_power_down       = cur_ff.pd;
  // same request on the dedicated pin and in-band rts
  assign pins.host_wake_req  = cur_ff.host_wake ~^ host_wake_pol;
  assign pins.uart_rts       = cur_ff.host_wake ~^ host_wake_pol;
  assign pins.host_irq       = cur_ff.irq;

endmodule

// ===== hw/swp_host.sv
// Purpose: host end driving wake requests, chip select and regulator enable
// Assumes: same clock as the device end
// Notes:   the host sees device wake outputs through three flops
`timescale 1ns/100ps
module swp_host (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // pins toward the device
  swp_if.host                        pins,
  // host software side
  input  wire logic                  want_awake,
  input  wire logic                  spi_access,
  input  wire logic                  power_on,
  input  wire logic                  dev_wake_pol,
  input  wire logic                  host_wake_pol,
  input  wire swp_pkg::swp_xport_t   xport_mode,
  output logic                       host_must_wake,
  output logic                       need_init
);

  typedef struct packed {
    logic [2:0] hw_sy;
    logic [2:0] rts_sy;
    logic [2:0] irq_sy;
    logic       hw_lvl;
    logic       rts_lvl;
    logic       irq_lvl;
    logic       reg_en;
    logic       init;
  } swp_host_state_t;

  swp_host_state_t cur_ff;
  swp_host_state_t nxt_cur;
  logic            wake_lvl;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.hw_sy  = {cur_ff.hw_sy[1:0], pins.host_wake_req};
    nxt_cur.rts_sy = {cur_ff.rts_sy[1:0], pins.uart_rts};
    nxt_cur.irq_sy = {cur_ff.irq_sy[1:0], pins.host_irq};
    if (cur_ff.hw_sy[1] == cur_ff.hw_sy[2])   nxt_cur.hw_lvl  = cur_ff.hw_sy[2];
    if (cur_ff.rts_sy[1] == cur_ff.rts_sy[2]) nxt_cur.rts_lvl = cur_ff.rts_sy[2];
    if (cur_ff.irq_sy[1] == cur_ff.irq_sy[2]) nxt_cur.irq_lvl = cur_ff.irq_sy[2];
    nxt_cur.reg_en = power_on;
    // a rising regulator enable means a cold device
    if (power_on && !cur_ff.reg_en) nxt_cur.init = 1'b1;
    else if (want_awake) nxt_cur.init = 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '{hw_sy: 3'h0, rts_sy: 3'h0, irq_sy: 3'h0, hw_lvl: 1'b0,
                 rts_lvl: 1'b0, irq_lvl: 1'b0, reg_en: 1'b0, init: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign wake_lvl               = want_awake ~^ dev_wake_pol;
  assign pins.dev_wake_req      = wake_lvl;
  assign pins.uart_cts          = wake_lvl;
  // idle transports while sleeping; select asserted to wake or access
  assign pins.host_port_select_n = !((want_awake || spi_access)
                                     && xport_mode == swp_pkg::SWP_XPORT_SPI);
  assign pins.regulator_enable  = cur_ff.reg_en;
  assign host_must_wake = ((xport_mode == swp_pkg::SWP_XPORT_UART ? cur_ff.rts_lvl
                            : cur_ff.hw_lvl) == host_wake_pol)
                          || cur_ff.irq_lvl;
  assign need_init = cur_ff.init;

endmodule

// ===== tb/swp_asserts.sv
// Purpose: checker for the sleep/wake pins between host and device ends
// Assumes: one clock; watched signals are the bundle less host_irq, plus a few device outputs
// Notes:   wake figures allow for the three-flop input filter and one state edge
`timescale 1ns/100ps
module swp_asserts (
  // clock and reset
  input wire logic                clk,
  input wire logic                reset_n,
  // bundle signals
  input wire logic                dev_wake_req,
  input wire logic                host_wake_req,
  input wire logic                uart_cts,
  input wire logic                uart_rts,
  input wire logic                host_port_select_n,
  input wire logic                regulator_enable,
  // device side
  input wire swp_pkg::swp_xport_t xport_mode,
  input wire logic                dev_wake_pol,
  input wire logic                refclk_polarity_strap,
  input wire logic                awake,
  input wire logic                event_active,
  input wire logic                regulators_on,
  input wire logic                core_retain,
  input wire logic                nonessential_clk_en,
  input wire logic                refclk_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // settled uart mode only: cts and rts are driven from the same values as the wake pins in every mode
  a_cts_tracks_wake:
    assert property ((xport_mode == swp_pkg::SWP_XPORT_UART)[*3] |-> uart_cts == dev_wake_req)
      else $error("cts differs from device wake pin");
  a_rts_tracks_hwake:
    assert property ((xport_mode == swp_pkg::SWP_XPORT_UART)[*3] |-> uart_rts == host_wake_req)
      else $error("rts differs from host wake pin");
  a_wake_keeps_awake:
    assert property ((regulator_enable && xport_mode != swp_pkg::SWP_XPORT_SPI
                      && dev_wake_req == dev_wake_pol)[*8] |-> awake || event_active)
      else $error("device asleep under held wake request");
  a_select_keeps_awake:
    assert property ((regulator_enable && xport_mode == swp_pkg::SWP_XPORT_SPI
                      && !host_port_select_n)[*8] |-> awake || event_active)
      else $error("device asleep under chip select");
  a_off_stays_down:
    assert property ((!regulator_enable)[*8] |-> !awake && !event_active)
      else $error("device active with regulators disabled");
  a_core_held_on:
    assert property (regulators_on && $past(regulators_on) |-> core_retain)
      else $error("core retention dropped while powered");
  a_sleep_gates_clk:
    assert property (regulators_on && !awake && !event_active |-> !nonessential_clk_en)
      else $error("nonessential clock running in sleep");
  a_refclk_while_awake:
    assert property (awake && $past(awake) |-> refclk_request == refclk_polarity_strap)
      else $error("reference clock request wrong while awake");

  cover property ($rose(awake));
  cover property ($rose(event_active));
  cover property ($fell(host_port_select_n) ##[1:20] awake);
endmodule

// ===== tb/sleep_wake_power_control_tb_top.sv
// Purpose: drives host and device ends joined by the wake bundle
// Assumes: both ends on one 125 MHz clock, short counts set by the bench
// Notes:   waits sample at the falling edge where all outputs have settled
`timescale 1ns/100ps
module sleep_wake_power_control_tb_top;
  logic                        clk, reset_n, strap, sleep_enable, dev_wake_pol, host_wake_pol;
  logic                        spi_idle_sleep_en, session_enable, timed_wake_en, event_done;
  logic                        data_pending, host_asleep, rf_tx_active, rf_rx_active;
  logic                        want_awake, spi_access, power_on, host_must_wake, need_init;
  logic                        regulators_on, core_retain, nonessential_pwr_on;
  logic                        nonessential_clk_en, refclk_request, event_active;
  logic                        fresh_power, awake;
  logic [swp_pkg::SWP_PD_W-1:0] rf_power_down;
  logic [15:0]                 spi_idle_time, event_period, timed_wake;
  swp_pkg::swp_xport_t         xport_mode;
  int                          n_fail, n_checks;

  swp_if bus ();
  swp_device u_swp_device (.clk(clk), .reset_n(reset_n), .pins(bus),
    .refclk_polarity_strap(strap), .xport_mode(xport_mode), .sleep_enable(sleep_enable),
    .dev_wake_pol(dev_wake_pol), .host_wake_pol(host_wake_pol),
    .spi_idle_sleep_en(spi_idle_sleep_en), .spi_idle_time(spi_idle_time),
    .session_enable(session_enable), .event_period(event_period), .timed_wake(timed_wake),
    .timed_wake_en(timed_wake_en), .event_done(event_done), .data_pending(data_pending),
    .host_asleep(host_asleep), .rf_tx_active(rf_tx_active), .rf_rx_active(rf_rx_active),
    .regulators_on(regulators_on), .core_retain(core_retain),
    .nonessential_pwr_on(nonessential_pwr_on), .nonessential_clk_en(nonessential_clk_en),
    .refclk_request(refclk_request), .event_active(event_active),
    .fresh_power(fresh_power), .rf_power_down(rf_power_down), .awake(awake));
  swp_host u_swp_host (.clk(clk), .reset_n(reset_n), .pins(bus), .want_awake(want_awake),
    .spi_access(spi_access), .power_on(power_on), .dev_wake_pol(dev_wake_pol),
    .host_wake_pol(host_wake_pol), .xport_mode(xport_mode),
    .host_must_wake(host_must_wake), .need_init(need_init));
  swp_asserts u_chk (.clk(clk), .reset_n(reset_n), .dev_wake_req(bus.dev_wake_req),
    .host_wake_req(bus.host_wake_req), .uart_cts(bus.uart_cts), .uart_rts(bus.uart_rts),
    .host_port_select_n(bus.host_port_select_n), .regulator_enable(bus.regulator_enable),
    .xport_mode(xport_mode), .dev_wake_pol(dev_wake_pol), .refclk_polarity_strap(strap),
    .awake(awake), .event_active(event_active), .regulators_on(regulators_on),
    .core_retain(core_retain), .nonessential_clk_en(nonessential_clk_en),
    .refclk_request(refclk_request));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task end_sim;
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %0t %s", $time, m);
      n_fail++;
    end
  endtask

  // waits by index: 0 awake, 1 event, 2 irq, 3 regulators
  function automatic logic sig(input int k);
    case (k)
      0: return awake;
      1: return event_active;
      2: return bus.host_irq;
      default: return regulators_on;
    endcase
  endfunction

  task automatic wt(input int k, input logic v, input int n, input string m);
    for (int i = 0; i < n && sig(k) !== v; i++) @(negedge clk);
    chk(sig(k), v, m);
    if (sig(k) !== v) end_sim();
    repeat (2) @(negedge clk);
  endtask

  task t_power;
    power_on = 1'b1;
    // init request stands one cycle only: the host already asks for the device
    @(negedge clk);
    chk(need_init, 1'b1, "host not asked to initialise");
    wt(0, 1'b1, 40, "no wake after power on");
    chk(refclk_request, strap, "refclk request level");
  endtask

  task t_pins;
    for (int p = 0; p < 2; p++) begin
      dev_wake_pol = p[0];
      host_wake_pol = p[0];
      sleep_enable = 1'b1;
      want_awake = 1'b0;
      wt(0, 1'b0, 40, "no sleep after wake removed");
      chk(bus.dev_wake_req, ~p[0], "idle wake pin level");
      chk(bus.host_wake_req, ~p[0], "idle host wake level");
      chk(nonessential_pwr_on | nonessential_clk_en, 1'b0, "sleep not gated");
      chk(refclk_request, ~strap, "refclk kept in sleep");
      chk(&rf_power_down, 1'b1, "radio powered in sleep");
      want_awake = 1'b1;
      repeat (2) @(negedge clk);
      chk(bus.dev_wake_req, p[0], "active wake pin level");
      wt(0, 1'b1, 20, "host wake ignored");
      host_asleep = 1'b1;
      data_pending = 1'b1;
      repeat (6) @(negedge clk);
      chk(bus.host_wake_req, p[0], "host not woken");
      host_asleep = 1'b0;
      data_pending = 1'b0;
    end
    dev_wake_pol = swp_pkg::SWP_DEV_WAKE_POL_RST;
    host_wake_pol = swp_pkg::SWP_HOST_WAKE_POL_RST;
  endtask

  task t_uart;
    xport_mode = swp_pkg::SWP_XPORT_UART;
    want_awake = 1'b0;
    wt(0, 1'b0, 40, "uart idle no sleep");
    chk(bus.uart_cts, ~dev_wake_pol, "cts idle level");
    want_awake = 1'b1;
    wt(0, 1'b1, 20, "cts wake ignored");
    chk(bus.uart_rts, ~host_wake_pol, "rts idle level");
    xport_mode = swp_pkg::SWP_XPORT_PINS;
  endtask

  task t_timed;
    want_awake = 1'b0;
    wt(0, 1'b0, 40, "no sleep before timed wake");
    timed_wake_en = 1'b1;
    // fires once the count passes timed_wake, awake one edge later
    repeat (33) @(negedge clk);
    chk(awake, 1'b0, "timed wake too early");
    wt(0, 1'b1, 40, "timed wake missing");
    timed_wake_en = 1'b0;
  endtask

  task t_session;
    wt(0, 1'b0, 40, "no sleep before session");
    session_enable = 1'b1;
    for (int e = 0; e < 2; e++) begin
      wt(1, 1'b1, 120, "scheduled event missing");
      want_awake = e[0];
      repeat (8) @(negedge clk);
      event_done = 1'b1;
      @(negedge clk);
      event_done = 1'b0;
      wt(1, 1'b0, 10, "event did not end");
      chk(awake, e[0], "state after event");
    end
    session_enable = 1'b0;
  endtask

  task t_spi;
    xport_mode = swp_pkg::SWP_XPORT_SPI;
    spi_idle_sleep_en = 1'b1;
    spi_access = 1'b0;
    // a held wake request would keep select low and the port busy
    want_awake = 1'b0;
    repeat (8) @(negedge clk);
    chk(awake, 1'b1, "slept before idle time");
    wt(0, 1'b0, 60, "no sleep on idle port");
    host_asleep = 1'b1;
    data_pending = 1'b1;
    wt(2, 1'b1, 30, "no interrupt for pending data");
    repeat (5) @(negedge clk);
    chk(host_must_wake, 1'b1, "host not told to wake");
    host_asleep = 1'b0;
    data_pending = 1'b0;
    wt(2, 1'b0, 30, "interrupt stuck");
    wt(0, 1'b0, 60, "no sleep after interrupt");
    spi_access = 1'b1;
    // wake pin must settle before leaving spi mode, or the device naps
    want_awake = 1'b1;
    repeat (2) @(negedge clk);
    chk(bus.host_port_select_n, 1'b0, "select not driven");
    wt(0, 1'b1, 20, "select did not wake");
    xport_mode = swp_pkg::SWP_XPORT_PINS;
    spi_idle_sleep_en = 1'b0;
    spi_access = 1'b0;
  endtask

  task t_rf;
    for (int r = 0; r < 2; r++) begin
      rf_tx_active = ~r[0];
      rf_rx_active = r[0];
      repeat (3) @(negedge clk);
      chk(rf_power_down[swp_pkg::SWP_PD_TX], r[0], "tx power-down");
      chk(rf_power_down[swp_pkg::SWP_PD_RX], ~r[0], "rx power-down");
      chk(rf_power_down[swp_pkg::SWP_PD_PA], r[0], "pa power-down");
      chk(rf_power_down[swp_pkg::SWP_PD_PLL], 1'b0, "pll power-down");
    end
    rf_rx_active = 1'b0;
  endtask

  task t_cycle;
    power_on = 1'b0;
    wt(3, 1'b0, 20, "regulators stay on");
    chk(awake, 1'b0, "awake without power");
    // freshness is set by the power reset; the held wake clears it right after power-up
    chk(fresh_power, 1'b1, "not treated as fresh");
    power_on = 1'b1;
    wt(3, 1'b1, 20, "regulators stay off");
    wt(0, 1'b1, 40, "no wake after power cycle");
  endtask

  initial begin
    n_fail = 0;
    n_checks = 0;
    {reset_n, sleep_enable, spi_idle_sleep_en, session_enable, timed_wake_en} = '0;
    {event_done, data_pending, host_asleep, rf_tx_active, rf_rx_active} = '0;
    {spi_access, power_on} = '0;
    {strap, want_awake} = 2'h3;
    dev_wake_pol = swp_pkg::SWP_DEV_WAKE_POL_RST;
    host_wake_pol = swp_pkg::SWP_HOST_WAKE_POL_RST;
    xport_mode = swp_pkg::SWP_XPORT_PINS;
    spi_idle_time = 16'h0010;
    event_period = 16'h0030;
    timed_wake = 16'h0020;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    t_power();
    t_pins();
    t_uart();
    t_timed();
    t_session();
    t_spi();
    t_rf();
    t_cycle();
    // second reset with the strap flipped, taken at the first edge after release
    power_on = 1'b0;
    reset_n = 1'b0;
    strap = 1'b0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    t_power();
    end_sim();
  end
endmodule
